// ===== hdl/tpw_pkg.sv
// Constants and state type of the three-phase PWM timer.
// Assumes one 100 MHz clock and an APB register port.
package tpw_pkg;
  // Counter and field widths
  localparam int CNT_W = 12;
  localparam int DEAD_W = 6;
  localparam int PDEL_W = 7;
  localparam int DIVC_W = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_DUTY_A = 8'h08;
  localparam logic [7:0] OFS_DUTY_B = 8'h0c;
  localparam logic [7:0] OFS_DUTY_C = 8'h10;
  localparam logic [7:0] OFS_DEAD = 8'h14;
  localparam logic [7:0] OFS_PDEL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Control and status field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIV_BIT = 1;
  localparam int STAT_DIR_BIT = 12;
  localparam int STAT_STOP_BIT = 13;
  localparam int STAT_RUN_BIT = 14;
  // Reset values
  localparam logic [CNT_W-1:0] PERIOD_RST = 12'hfff;
  localparam logic [CNT_W-1:0] DUTY_RST = 12'h000;
  localparam logic [DEAD_W-1:0] DEAD_RST = 6'h00;
  localparam logic [PDEL_W-1:0] PDEL_RST = 7'h00;
  // Timing: system clock may not exceed 12.5 MHz
  localparam int CLK_KHZ = 100000;
  localparam int SYS_MAX_KHZ = 12500;
  localparam int SYS_DIV = (CLK_KHZ + SYS_MAX_KHZ - 1) / SYS_MAX_KHZ;

  typedef struct packed {
    logic en;
    logic div2;
    logic [CNT_W-1:0] per;
    logic [2:0][CNT_W-1:0] duty;
    logic [DEAD_W-1:0] dt;
    logic [PDEL_W-1:0] pdel;
    logic [DIVC_W-1:0] divc;
    logic tick;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] per_sh;
    logic dir;
    logic [2:0][CNT_W:0] eff;
    logic [2:0] lvl;
    logic [2:0][DEAD_W:0] dead;
    logic [2:0] hi;
    logic [2:0] lo;
    logic sync;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tpw_state_t;
endpackage : tpw_pkg

// ===== hdl/tpw_timer.sv
// Three-phase center-based PWM timer with deadtime and pulse deletion.
// Assumes an APB master on clk_in; stop_in is synchronous to clk_in.
// Behaviour
// - Timer counter is twelve bits wide, giving up to 4096 duty steps.
// - Deadtime is programmed in steps of two system ticks, 0 to 126 ticks.
// - Pulse deletion is programmed per tick, 0 to 127; narrower pulses are dropped.
// - Full twelve-bit period reaches the lowest switching frequency, about 1.5 kHz, or about 0.76 kHz with the divide-down bit.
// - Shorter periods give higher frequency with fewer effective duty bits.
// - System tick stays at or below 12.5 MHz; divide-down bit halves it further.
// - Register writes complete with zero wait states, captured in that cycle.
// - Shutdown input forces every PWM output off.
// - Three phases, each with a main and complementary output.
//
// Added by the designer: the address map and the APB slave port.
module tpw_timer #(
  parameter int SYS_DIV = tpw_pkg::SYS_DIV
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Shutdown and sync
  input wire logic stop_in,
  output logic pwm_sync_out,
  // Phase outputs
  output logic phase_a_out,
  output logic phase_a_complement_out,
  output logic phase_b_out,
  output logic phase_b_complement_out,
  output logic phase_c_out,
  output logic phase_c_complement_out
);
  localparam int CW = tpw_pkg::CNT_W;
  localparam int DW = tpw_pkg::DIVC_W;

  // Divider counter must hold twice the base ratio; one clock per tick would break the tick spacing
  if (SYS_DIV < 2 || SYS_DIV > 16) begin : g_bad_div
    $error("SYS_DIV must lie in 2..16");
  end

  tpw_pkg::tpw_state_t s;
  tpw_pkg::tpw_state_t next_s;

  // Effective compare level after pulse deletion; narrow pulses vanish
  function automatic logic [CW:0] eff_duty(input logic [CW-1:0] duty, input logic [CW-1:0] per,
                                           input logic [tpw_pkg::PDEL_W-1:0] pdel);
    logic [CW:0] on_t;
    logic [CW:0] off_t;
    on_t = {duty, 1'b0};
    off_t = (duty >= per) ? '0 : {per - duty, 1'b0};
    if (on_t < {6'h00, pdel}) begin
      eff_duty = '0;
    end else if (duty >= per || off_t < {6'h00, pdel}) begin
      // Compare level above the peak keeps the main output on all period
      eff_duty = {1'b0, per} + 13'h0001;
    end else begin
      eff_duty = {1'b0, duty};
    end
  endfunction : eff_duty

  // Next-state logic
  always_comb begin
    logic [DW-1:0] lim;
    logic want;
    lim = s.div2 ? DW'(2 * SYS_DIV - 1) : DW'(SYS_DIV - 1);
    want = 1'b0;
    next_s = s;
    next_s.tick = 1'b0;
    next_s.sync = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    // Setup phase: answer is ready for the following access edge
    if (psel_in && !penable_in) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr_in)
        tpw_pkg::OFS_CTRL: next_s.prdata[1:0] = {s.div2, s.en};
        tpw_pkg::OFS_PERIOD: next_s.prdata[CW-1:0] = s.per;
        tpw_pkg::OFS_DUTY_A: next_s.prdata[CW-1:0] = s.duty[0];
        tpw_pkg::OFS_DUTY_B: next_s.prdata[CW-1:0] = s.duty[1];
        tpw_pkg::OFS_DUTY_C: next_s.prdata[CW-1:0] = s.duty[2];
        tpw_pkg::OFS_DEAD: next_s.prdata[tpw_pkg::DEAD_W-1:0] = s.dt;
        tpw_pkg::OFS_PDEL: next_s.prdata[tpw_pkg::PDEL_W-1:0] = s.pdel;
        tpw_pkg::OFS_STATUS: begin
          next_s.prdata[CW-1:0] = s.cnt;
          next_s.prdata[tpw_pkg::STAT_DIR_BIT] = s.dir;
          next_s.prdata[tpw_pkg::STAT_STOP_BIT] = stop_in;
          next_s.prdata[tpw_pkg::STAT_RUN_BIT] = s.en;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // Write takes effect at the single access edge
    if (psel_in && penable_in && s.pready && pwrite_in && !s.pslverr) begin
      unique case (paddr_in)
        tpw_pkg::OFS_CTRL: begin
          next_s.en = pwdata_in[tpw_pkg::CTRL_EN_BIT];
          next_s.div2 = pwdata_in[tpw_pkg::CTRL_DIV_BIT];
        end
        tpw_pkg::OFS_PERIOD: next_s.per = pwdata_in[CW-1:0];
        tpw_pkg::OFS_DUTY_A: next_s.duty[0] = pwdata_in[CW-1:0];
        tpw_pkg::OFS_DUTY_B: next_s.duty[1] = pwdata_in[CW-1:0];
        tpw_pkg::OFS_DUTY_C: next_s.duty[2] = pwdata_in[CW-1:0];
        tpw_pkg::OFS_DEAD: next_s.dt = pwdata_in[tpw_pkg::DEAD_W-1:0];
        tpw_pkg::OFS_PDEL: next_s.pdel = pwdata_in[tpw_pkg::PDEL_W-1:0];
        default: ;
      endcase
    end

    // System tick divider; disabled timer parks at the valley
    if (!s.en) begin
      next_s.divc = '0;
      next_s.cnt = '0;
      next_s.dir = 1'b0;
      next_s.lvl = 3'b000;
      next_s.dead = '0;
    end else if (s.divc >= lim) begin
      next_s.divc = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.divc = s.divc + DW'(1);
    end

    // Up/down counter; shadows load at the valley so a period never tears
    if (s.en && s.tick) begin
      if (s.dir) begin
        if (s.cnt >= s.per_sh) begin
          next_s.dir = 1'b0;
        end else begin
          next_s.cnt = s.cnt + CW'(1);
        end
      end else if (s.cnt == '0) begin
        next_s.dir = 1'b1;
        next_s.sync = 1'b1;
        next_s.per_sh = s.per;
        for (int i = 0; i < 3; i++) begin
          next_s.eff[i] = eff_duty(s.duty[i], s.per, s.pdel);
        end
      end else begin
        next_s.cnt = s.cnt - CW'(1);
      end
      // Deadtime: a level change blanks both outputs for 2*dt ticks
      for (int i = 0; i < 3; i++) begin
        want = {1'b0, s.cnt} < s.eff[i];
        if (want != s.lvl[i]) begin
          next_s.lvl[i] = want;
          next_s.dead[i] = {s.dt, 1'b0};
        end else if (s.dead[i] != '0) begin
          next_s.dead[i] = s.dead[i] - 7'h01;
        end
      end
    end

    // Outputs: never both high of a pair, all off on shutdown
    for (int i = 0; i < 3; i++) begin
      next_s.hi[i] = next_s.en && !stop_in && next_s.dead[i] == '0 && next_s.lvl[i];
      next_s.lo[i] = next_s.en && !stop_in && next_s.dead[i] == '0 && !next_s.lvl[i];
    end
  end

  // State register; reset values put the pins in the safe off state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
      s.per <= tpw_pkg::PERIOD_RST;
      s.per_sh <= tpw_pkg::PERIOD_RST;
      s.duty <= {3{tpw_pkg::DUTY_RST}};
      s.dt <= tpw_pkg::DEAD_RST;
      s.pdel <= tpw_pkg::PDEL_RST;
    end else begin
      s <= next_s;
    end
  end

  // Ports come straight from state flops
  assign prdata_out = s.prdata;
  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign pwm_sync_out = s.sync;
  assign phase_a_out = s.hi[0];
  assign phase_a_complement_out = s.lo[0];
  assign phase_b_out = s.hi[1];
  assign phase_b_complement_out = s.lo[1];
  assign phase_c_out = s.hi[2];
  assign phase_c_complement_out = s.lo[2];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // Bus steps: setup followed by a write access to duty A
  sequence seq_setup;
    psel_in && !penable_in;
  endsequence
  sequence seq_wr_duty_a;
    psel_in && penable_in && pwrite_in && paddr_in == tpw_pkg::OFS_DUTY_A;
  endsequence

  AST_READY: assert property (seq_setup |=> pready_out)
    else $error("pready not given after setup");
  AST_WRITE: assert property (seq_setup ##1 seq_wr_duty_a |=> s.duty[0] == $past(pwdata_in[11:0]))
    else $error("duty A write not captured");
  AST_STOP: assert property (stop_in |=> !(|{s.hi, s.lo}))
    else $error("outputs active during shutdown");
  AST_PAIR: assert property ((s.hi & s.lo) == 3'b000)
    else $error("main and complement high together");
  AST_CNT: assert property (s.en && s.per_sh != '0 |-> s.cnt <= s.per_sh)
    else $error("counter left its period");
  AST_DEAD: assert property (s.en && s.tick && ({1'b0, s.cnt} < s.eff[0]) != s.lvl[0]
                            |=> s.dead[0] == {$past(s.dt), 1'b0} && (s.dead[0] == '0 || !phase_a_out))
    else $error("deadtime not loaded on edge");
  AST_HOLD: assert property (s.dead[1] != '0 && !s.tick && s.en |=> s.dead[1] == $past(s.dead[1]))
    else $error("deadtime counted off the tick");
  AST_TICK: assert property (s.tick |=> !s.tick)
    else $error("system tick on two clocks in a row");

  // Clocks since the last tick; saturates so a long disabled spell cannot wrap
  logic [DW:0] tick_gap;
  logic tick_seen;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_gap <= '0;
      tick_seen <= 1'b0;
    end else if (s.tick) begin
      tick_gap <= '0;
      tick_seen <= 1'b1;
    end else if (tick_gap != '1) begin
      tick_gap <= tick_gap + (DW + 1)'(1);
    end
  end

  // Tick spacing never shorter than the base divide ratio
  AST_TICK_GAP: assert property (s.tick && tick_seen |-> tick_gap >= (DW + 1)'(SYS_DIV - 1))
    else $error("system tick too fast");

  // Valley steps: the period start pulse comes in the same clock as the turn at count zero
  sequence seq_valley;
    s.sync && s.cnt == '0 && s.dir;
  endsequence

  AST_SYNC: assert property (s.sync |-> seq_valley)
    else $error("sync pulse away from the valley");
  AST_SYNC_PULSE: assert property (s.sync |=> !s.sync)
    else $error("sync pulse longer than one clock");
  AST_LOAD: assert property (s.sync |-> s.per_sh == $past(s.per))
    else $error("period shadow not loaded at valley");
  AST_OFF: assert property (!s.en |-> !(|{s.hi, s.lo}))
    else $error("outputs active while disabled");
  AST_DEAD_MAX: assert property (s.dead[0] <= 7'h7e && s.dead[1] <= 7'h7e && s.dead[2] <= 7'h7e)
    else $error("deadtime count beyond its range");
  AST_ERR: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
    else $error("error answer without ready or with data");
  AST_PDEL: assert property (s.sync && {$past(s.duty[2]), 1'b0} < {6'h00, $past(s.pdel)}
                            && $past(s.per) == s.per_sh |-> s.eff[2] == '0)
    else $error("narrow pulse not deleted");
endmodule : tpw_timer

// ===== tb/three_phase_pwm_timer_bench.sv
// Self-checking bench of the PWM timer: register table, then waveform cases.
// Assumes a shortened system tick of two clocks to keep the run brief.
module three_phase_pwm_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2;
  typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] data; logic [31:0] exp; logic err;} tpw_row_t;
  logic clk_in, rstn_in, stop_in, psel, penable, pwrite, pready, pslverr, sync, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] main_o, comp_o;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_clk;
  int hi_m [3];
  int hi_c [3];
  tpw_row_t rows [15];
  tpw_timer #(.SYS_DIV(DIV)) DUT (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .stop_in(stop_in), .pwm_sync_out(sync), .phase_a_out(main_o[0]),
    .phase_a_complement_out(comp_o[0]), .phase_b_out(main_o[1]), .phase_b_complement_out(comp_o[1]),
    .phase_c_out(main_o[2]), .phase_c_complement_out(comp_o[2]));
  tpw_host host (.clk_in(clk_in), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Hang guard, well above the longest expected run
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, er);
  endtask : wr
  // Program, skip to a fresh period (new values load at the valley), count one period
  task automatic pwm(input int per, duty, dt, pdel, ctrl, exp_m, exp_c);
    int tick;
    int p;
    tick = DIV * ((ctrl & 2) != 0 ? 2 : 1);
    p = (2 * per + 2) * tick;
    wr(tpw_pkg::OFS_PERIOD, per);
    for (int i = 0; i < 3; i++) wr(tpw_pkg::OFS_DUTY_A + 8'(4 * i), duty);
    wr(tpw_pkg::OFS_DEAD, dt);
    wr(tpw_pkg::OFS_PDEL, pdel);
    wr(tpw_pkg::OFS_CTRL, ctrl);
    @(posedge clk_in iff sync === 1'b1);
    @(posedge clk_in iff sync === 1'b1);
    n_clk = 0;
    hi_m = '{0, 0, 0};
    hi_c = '{0, 0, 0};
    do begin
      @(posedge clk_in);
      n_clk++;
      for (int i = 0; i < 3; i++) begin
        hi_m[i] += main_o[i];
        hi_c[i] += comp_o[i];
      end
    end while (sync !== 1'b1);
    chk("period", n_clk, p);
    for (int i = 0; i < 3; i++) begin
      chk("blank", hi_m[i] + hi_c[i], p - 4 * dt * tick);
      if (exp_m >= 0) chk("main", hi_m[i], exp_m);
      if (exp_c >= 0) chk("comp", hi_c[i], exp_c);
    end
  endtask : pwm
  initial begin
    rows = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 32'hfff, 0}, '{0, 8'h08, 0, 0, 0}, '{0, 8'h0c, 0, 0, 0},
      '{0, 8'h10, 0, 0, 0}, '{0, 8'h14, 0, 0, 0}, '{0, 8'h18, 0, 0, 0}, '{1, 8'h04, 32'h123, 0, 0},
      '{0, 8'h04, 0, 32'h123, 0}, '{1, 8'h14, 32'hffffffff, 0, 0}, '{0, 8'h14, 0, 32'h3f, 0},
      '{1, 8'h18, 32'hffffffff, 0, 0}, '{0, 8'h18, 0, 32'h7f, 0}, '{1, 8'h20, 32'h5, 0, 1}, '{0, 8'h20, 0, 0, 1}};
    rstn_in = 1'b0;
    stop_in = 1'b0;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    // Register table: reset values, field widths, unmapped place
    foreach (rows[k]) begin
      host.xfer(rows[k].wr, rows[k].addr, rows[k].data, rd, er);
      if (!rows[k].wr) chk("rdata", rd, rows[k].exp);
      chk("slverr", er, rows[k].err);
    end
    // Waveform cases, long full-range period last
    pwm(10, 5, 3, 0, 1, -1, -1);
    pwm(10, 5, 3, 0, 3, -1, -1);
    pwm(10, 2, 0, 5, 1, 0, 44);
    pwm(10, 2, 0, 4, 1, -1, -1);
    chk("not_deleted", hi_m[0] > 0, 1);
    pwm(10, 10, 0, 0, 1, 44, 0);
    pwm(10, 0, 0, 0, 1, 0, 44);
    pwm(4095, 2048, 0, 0, 1, -1, -1);
    // Shutdown blanks every output while the timer runs
    stop_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk("stop_out", {main_o, comp_o}, 0);
    host.xfer(1'b0, tpw_pkg::OFS_STATUS, 0, rd, er);
    chk("status", rd & 32'h6000, 32'h6000);
    stop_in <= 1'b0;
    // Reset in mid-run, shortest legal length
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk("rst_out", {main_o, comp_o, sync, pready}, 0);
    @(posedge clk_in);
    rstn_in <= 1'b1;
    host.xfer(1'b0, tpw_pkg::OFS_CTRL, 0, rd, er);
    chk("ctrl_rst", rd, 0);
    end_of_test();
  end
endmodule : three_phase_pwm_timer_bench

// ===== tb/tpw_host.sv
// Host model that owns the register port of the PWM timer.
// Assumes an APB slave on the same clock; a hung slave is cut off by the bench timeout.
module tpw_host (
  // Clock
  input wire logic clk_in,
  // APB master side
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  // One whole transfer, held until ready; released lines flip so stale data never looks valid
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= addr;
    pwdata_out <= data;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rdata = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~addr;
    pwdata_out <= ~data;
  endtask : xfer
endmodule : tpw_host
